// ==== pcrs_pkg.sv ====
// pcrs_pkg: constants and types for the pwm configuration register block
// assumes an 8-bit special-function register bus with a byte address
package pcrs_pkg;

  localparam logic [7:0] PCRS_CFG_ADDR     = 8'hf7;
  localparam logic [7:0] PCRS_CFG_RESET    = 8'h00;
  localparam int         PCRS_BIT_BANK     = 7;
  localparam int         PCRS_BIT_IRQ_EN   = 6;
  localparam int         PCRS_BIT_FLAG     = 5;
  localparam int         PCRS_BIT_RELOAD   = 3;
  localparam int         PCRS_CLSEL_LSB    = 0;
  localparam int         PCRS_NUM_CH       = 3;
  localparam int         PCRS_CH_W         = 2;
  localparam int         PCRS_BASE_LEN     = 8;
  localparam logic [15:0] PCRS_WORD_RESET  = 16'h0000;

  // channel modes as seen by this block
  localparam logic [1:0] PCRS_MODE_OTHER   = 2'h0;
  localparam logic [1:0] PCRS_MODE_PWM_N   = 2'h1;
  localparam logic [1:0] PCRS_MODE_PWM_16  = 2'h2;

  typedef struct packed {
    logic       bank_sel;
    logic       irq_en;
    logic       flag;
    logic       wide_reload;
    logic [2:0] cycle_len;
  } pcrs_cfg_s;

  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic                 hi;
    logic [PCRS_CH_W-1:0] ch;
    logic [7:0]           wdata;
  } pcrs_cmp_req_s;

endpackage

// ==== pcrs_cmp_bank.sv ====
// pcrs_cmp_bank: per-channel compare and auto-reload register pairs
// assumes the caller decodes compare byte accesses and the bank select
`timescale 1ns/1ns
`default_nettype none
module pcrs_cmp_bank
  import pcrs_pkg::*;
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      rstn_i,
  input  wire pcrs_cmp_req_s             req_i,
  input  wire logic                      bank_sel_i,
  input  wire logic                      reload_i,
  input  wire logic [PCRS_NUM_CH*2-1:0]  mode_i,
  output logic      [7:0]                rdata_o,
  output logic      [PCRS_NUM_CH*16-1:0] compare_o
);

  logic [15:0] cmp  [PCRS_NUM_CH];
  logic [15:0] arld [PCRS_NUM_CH];

  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction

  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < PCRS_NUM_CH; i++) begin
      if (!rstn_i) begin
        cmp[i]  <= PCRS_WORD_RESET;
        arld[i] <= PCRS_WORD_RESET;
      end else begin
        if (req_i.wr && req_i.ch == PCRS_CH_W'(i) && bank_sel_i) begin
          arld[i] <= put_byte(arld[i], req_i.hi, req_i.wdata);
        end
        if (req_i.wr && req_i.ch == PCRS_CH_W'(i) && !bank_sel_i) begin
          cmp[i] <= put_byte(cmp[i], req_i.hi, req_i.wdata);
        end else if (reload_i && mode_i[2*i +: 2] == PCRS_MODE_PWM_16) begin
          // software write wins over a same-cycle reload
          cmp[i] <= arld[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      if (bank_sel_i) begin
        rdata_o <= req_i.hi ? arld[req_i.ch][15:8] : arld[req_i.ch][7:0];
      end else begin
        rdata_o <= req_i.hi ? cmp[req_i.ch][15:8] : cmp[req_i.ch][7:0];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < PCRS_NUM_CH; i++) begin
      compare_o[16*i +: 16] = cmp[i];
    end
  end

endmodule
`default_nettype wire

// ==== pcrs_top.sv ====
// pcrs_top: pwm configuration register with reload bank steering
// assumes a synchronous sfr bus: one-cycle rd/wr strobes, read data next cycle
`timescale 1ns/1ns
`default_nettype none
module pcrs_top
  import pcrs_pkg::*;
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      rstn_i,
  input  wire logic [7:0]                sfr_addr_i,
  input  wire logic                      sfr_wr_i,
  input  wire logic                      sfr_rd_i,
  input  wire logic [7:0]                sfr_wdata_i,
  output logic      [7:0]                sfr_rdata_o,
  input  wire logic                      cmp_sel_i,
  input  wire logic                      cmp_hi_i,
  input  wire logic [PCRS_CH_W-1:0]      cmp_ch_i,
  input  wire logic [15:0]               main_counter_i,
  input  wire logic                      counter_ovf_i,
  input  wire logic [PCRS_NUM_CH*2-1:0]  channel_mode_i,
  output logic      [PCRS_NUM_CH*16-1:0] compare_o,
  output logic      [3:0]                cycle_bits_o,
  output logic                           cycle_ovf_irq_o
);

  pcrs_cfg_s     cfg;
  pcrs_cmp_req_s req;
  logic          cfg_hit;
  logic          cfg_rd_q;
  logic [7:0]    cfg_rdata;
  logic [7:0]    cmp_rdata;
  logic          prev_bit;
  logic          cur_bit;
  logic          cyc_ovf;
  logic          sw_flag_wr;

  // cycle length in bits for a length code: 8 at code 0 up to 15 at code 7
  function automatic logic [3:0] len_bits(input logic [2:0] code);
    len_bits = 4'(PCRS_BASE_LEN) + {1'b0, code};
  endfunction

  assign cfg_hit    = (sfr_addr_i == PCRS_CFG_ADDR);
  assign sw_flag_wr = sfr_wr_i && cfg_hit;

  assign req.wr    = sfr_wr_i && cmp_sel_i;
  assign req.rd    = sfr_rd_i && cmp_sel_i;
  assign req.hi    = cmp_hi_i;
  assign req.ch    = cmp_ch_i;
  assign req.wdata = sfr_wdata_i;

  assign cycle_bits_o = len_bits(cfg.cycle_len);

  // cycle overflow: counter bit n-1 carrying out, n = 8..15 by the length code
  assign cur_bit = main_counter_i[len_bits(cfg.cycle_len) - 4'h1];
  assign cyc_ovf = prev_bit && !cur_bit;

  // a length write re-arms the detector on the new bit, so a stale high left
  // by the old bit cannot fake an overflow
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      prev_bit <= 1'b0;
    end else if (sw_flag_wr) begin
      prev_bit <= main_counter_i[len_bits(sfr_wdata_i[PCRS_CLSEL_LSB +: 3]) - 4'h1];
    end else begin
      prev_bit <= cur_bit;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cfg <= pcrs_cfg_s'(7'h00);
    end else begin
      if (sw_flag_wr) begin
        cfg.bank_sel    <= sfr_wdata_i[PCRS_BIT_BANK];
        cfg.irq_en      <= sfr_wdata_i[PCRS_BIT_IRQ_EN];
        cfg.wide_reload <= sfr_wdata_i[PCRS_BIT_RELOAD];
        cfg.cycle_len   <= sfr_wdata_i[PCRS_CLSEL_LSB +: 3];
      end
      // hardware set wins over a same-cycle software clear
      if (cyc_ovf) begin
        cfg.flag <= 1'b1;
      end else if (sw_flag_wr) begin
        cfg.flag <= sfr_wdata_i[PCRS_BIT_FLAG];
      end
    end
  end

  assign cycle_ovf_irq_o = cfg.irq_en && cfg.flag;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cfg_rd_q  <= 1'b0;
      cfg_rdata <= PCRS_CFG_RESET;
    end else begin
      cfg_rd_q  <= sfr_rd_i && cfg_hit;
      cfg_rdata <= {cfg.bank_sel, cfg.irq_en, cfg.flag, 1'b0, cfg.wide_reload,
                    cfg.cycle_len};
    end
  end

  // config read data shows for one cycle; otherwise the bus holds the last compare read
  assign sfr_rdata_o = cfg_rd_q ? cfg_rdata : cmp_rdata;

  pcrs_cmp_bank u_bank (
    .clk_sys_i  (clk_sys_i),
    .rstn_i     (rstn_i),
    .req_i      (req),
    .bank_sel_i (cfg.bank_sel),
    .reload_i   (counter_ovf_i && cfg.wide_reload),
    .mode_i     (channel_mode_i),
    .rdata_o    (cmp_rdata),
    .compare_o  (compare_o)
  );

  // flag and interrupt
  chk_irq_gate_off: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !cfg.irq_en |-> !cycle_ovf_irq_o) else $error("irq raised while disabled");
  chk_irq_gate_on: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cfg.irq_en && cfg.flag |-> cycle_ovf_irq_o) else $error("irq missing");
  chk_flag_sets: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cyc_ovf |=> cfg.flag) else $error("overflow did not set flag");
  chk_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cfg.flag && !sw_flag_wr |=> cfg.flag) else $error("flag dropped by hw");
  chk_flag_sw_set: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sw_flag_wr && sfr_wdata_i[PCRS_BIT_FLAG]
    |=> cfg.flag)
    else $error("software set of flag lost");
  chk_flag_sw_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sw_flag_wr && !sfr_wdata_i[PCRS_BIT_FLAG] && !cyc_ovf
    |=> !cfg.flag)
    else $error("software clear of flag lost");
  chk_flag_no_hw_set: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !cfg.flag && !cyc_ovf && !(sw_flag_wr && sfr_wdata_i[PCRS_BIT_FLAG])
    |=> !cfg.flag)
    else $error("flag set without overflow");
  chk_ovf_irq: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cyc_ovf && cfg.irq_en && !sw_flag_wr
    |=> cycle_ovf_irq_o)
    else $error("overflow did not raise irq");
  chk_irq_off_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sw_flag_wr && !sfr_wdata_i[PCRS_BIT_IRQ_EN]
    |=> !cycle_ovf_irq_o)
    else $error("irq raised after enable cleared");
  // config register
  chk_len_map: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cycle_bits_o == 4'(8) + {1'b0, cfg.cycle_len}) else $error("bad cycle len");
  chk_len_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sw_flag_wr
    |=> cycle_bits_o == 4'h8 + {1'b0, $past(sfr_wdata_i[PCRS_CLSEL_LSB +: 3])})
    else $error("cycle length not taken from write");
  chk_cfg_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sw_flag_wr
    |=> cfg.bank_sel == $past(sfr_wdata_i[PCRS_BIT_BANK])
        && cfg.irq_en == $past(sfr_wdata_i[PCRS_BIT_IRQ_EN])
        && cfg.wide_reload == $past(sfr_wdata_i[PCRS_BIT_RELOAD]))
    else $error("config write lost");
  chk_cfg_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !sw_flag_wr
    |=> $stable(cfg.bank_sel) && $stable(cfg.irq_en) && $stable(cfg.wide_reload)
        && $stable(cfg.cycle_len))
    else $error("config changed without a write");
  chk_cfg_readback: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sfr_rd_i && cfg_hit
    |=> sfr_rdata_o[4] == 1'b0 && sfr_rdata_o[PCRS_BIT_FLAG] == $past(cfg.flag))
    else $error("config read back wrong");
  // compare steering and reload
  chk_bank_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sfr_wr_i && cmp_sel_i && cfg.bank_sel && !cmp_hi_i && cmp_ch_i == 2'h0 && !counter_ovf_i
    |=> $stable(compare_o[15:0])) else $error("reload bank write hit compare");
  chk_bank_hi_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sfr_wr_i && cmp_sel_i && cfg.bank_sel && cmp_hi_i && cmp_ch_i == 2'h1 && !counter_ovf_i
    |=> $stable(compare_o[31:16]))
    else $error("reload bank high write hit compare");
  chk_norm_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sfr_wr_i && cmp_sel_i && !cfg.bank_sel && !cmp_hi_i && cmp_ch_i == 2'h0
    |=> compare_o[7:0] == $past(sfr_wdata_i)) else $error("compare write lost");
  chk_hi_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sfr_wr_i && cmp_sel_i && !cfg.bank_sel && cmp_hi_i && cmp_ch_i == 2'h1
    |=> compare_o[31:24] == $past(sfr_wdata_i))
    else $error("high byte write lost");
  chk_rd_normal: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sfr_rd_i && cmp_sel_i && !cfg_hit && !cfg.bank_sel && !cmp_hi_i && cmp_ch_i == 2'h1
    |=> sfr_rdata_o == $past(compare_o[23:16]))
    else $error("normal bank read wrong");
  chk_read_quiet: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sfr_rd_i && !sfr_wr_i && !counter_ovf_i
    |=> $stable(compare_o))
    else $error("read disturbed compare");
  chk_no_reload: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !cfg.wide_reload && !(sfr_wr_i && cmp_sel_i && !cfg.bank_sel)
    |=> $stable(compare_o)) else $error("reload while disabled");
  chk_other_mode: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    channel_mode_i[5:4] == PCRS_MODE_OTHER
    && !(sfr_wr_i && cmp_sel_i && !cfg.bank_sel && cmp_ch_i == 2'h2)
    |=> $stable(compare_o[47:32]))
    else $error("reload reached a channel in another mode");
  chk_pwm_n_no_wide: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    counter_ovf_i && channel_mode_i[1:0] != PCRS_MODE_PWM_16
    && !(sfr_wr_i && cmp_sel_i && !cfg.bank_sel && cmp_ch_i == 2'h0)
    |=> $stable(compare_o[15:0]))
    else $error("wide reload reached a narrow channel");
  cov_irq: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) cycle_ovf_irq_o);
  cov_ovf: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) cyc_ovf);
  cov_reload: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    counter_ovf_i && cfg.wide_reload);
  cov_bank_write: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sfr_wr_i && cmp_sel_i && cfg.bank_sel);
  cov_flag_clear: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sw_flag_wr && cfg.flag && !sfr_wdata_i[PCRS_BIT_FLAG]);

endmodule
`default_nettype wire

// ==== pcrs_top_test.sv ====
// pcrs_top_test: self-checking bench for the pwm configuration register block
// assumes one-cycle sfr strobes and read data on the cycle after the strobe
`timescale 1ns/1ns
`default_nettype none
module pcrs_top_test
  import pcrs_pkg::*;
;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  sfr_addr_i = 8'h00;
  logic        sfr_wr_i = 1'b0;
  logic        sfr_rd_i = 1'b0;
  logic [7:0]  sfr_wdata_i = 8'h00;
  logic [7:0]  sfr_rdata_o;
  logic        cmp_sel_i = 1'b0;
  logic        cmp_hi_i = 1'b0;
  logic [1:0]  cmp_ch_i = 2'h0;
  logic [15:0] main_counter_i = 16'h0000;
  logic        counter_ovf_i = 1'b0;
  logic [5:0]  channel_mode_i = 6'h00;
  logic [47:0] compare_o;
  logic [3:0]  cycle_bits_o;
  logic        cycle_ovf_irq_o;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cycles = 0;

  pcrs_top dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .cmp_sel_i(cmp_sel_i), .cmp_hi_i(cmp_hi_i),
    .cmp_ch_i(cmp_ch_i), .main_counter_i(main_counter_i), .counter_ovf_i(counter_ovf_i),
    .channel_mode_i(channel_mode_i), .compare_o(compare_o), .cycle_bits_o(cycle_bits_o),
    .cycle_ovf_irq_o(cycle_ovf_irq_o));

  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // the whole run is under a hundred cycles; the ceiling leaves ample margin
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      test_done();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // one strobe cycle; compare accesses use an address other than the config one
  task automatic acc(input logic w, input logic sel, input logic hi, input logic [1:0] ch,
                     input logic [7:0] d);
    @(posedge clk_sys_i);
    sfr_wr_i    <= w;
    sfr_rd_i    <= !w;
    sfr_addr_i  <= sel ? 8'h00 : PCRS_CFG_ADDR;
    cmp_sel_i   <= sel;
    cmp_hi_i    <= hi;
    cmp_ch_i    <= ch;
    sfr_wdata_i <= d;
    @(posedge clk_sys_i);
    sfr_wr_i  <= 1'b0;
    sfr_rd_i  <= 1'b0;
    cmp_sel_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic sel, input logic hi, input logic [1:0] ch, input logic [7:0] e);
    acc(1'b0, sel, hi, ch, 8'h00);
    check({8'h00, sfr_rdata_o}, {8'h00, e});
  endtask

  task automatic wcmp(input logic [1:0] ch, input logic [15:0] v);
    acc(1'b1, 1'b1, 1'b1, ch, v[15:8]);
    acc(1'b1, 1'b1, 1'b0, ch, v[7:0]);
  endtask

  task automatic tick(input logic [15:0] v);
    @(posedge clk_sys_i);
    main_counter_i <= v;
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic pulse_ovf();
    @(posedge clk_sys_i);
    counter_ovf_i <= 1'b1;
    @(posedge clk_sys_i);
    counter_ovf_i <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(1'b0, 1'b0, 2'h0, 8'h00);
    check({12'h000, cycle_bits_o}, 16'h0008);
    acc(1'b1, 1'b0, 1'b0, 2'h0, 8'hff);
    rd(1'b0, 1'b0, 2'h0, 8'hef);
    check({15'h0000, cycle_ovf_irq_o}, 16'h0001);
    acc(1'b1, 1'b0, 1'b0, 2'h0, 8'ha0);
    check({15'h0000, cycle_ovf_irq_o}, 16'h0000);
    acc(1'b1, 1'b0, 1'b0, 2'h0, 8'h00);
    rd(1'b0, 1'b0, 2'h0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 1'b0, 1'b0, 2'h0, 8'(i));
      check({12'h000, cycle_bits_o}, 16'(8 + i));
    end
    // 9-bit cycle: a fall of bit 7 must not set the flag, a fall of bit 8 must
    acc(1'b1, 1'b0, 1'b0, 2'h0, 8'h41);
    tick(16'h0080);
    tick(16'h0000);
    check({15'h0000, cycle_ovf_irq_o}, 16'h0000);
    tick(16'h01ff);
    tick(16'h0200);
    check({15'h0000, cycle_ovf_irq_o}, 16'h0001);
    acc(1'b1, 1'b0, 1'b0, 2'h0, 8'h41);
    rd(1'b0, 1'b0, 2'h0, 8'h41);
    acc(1'b1, 1'b0, 1'b0, 2'h0, 8'h00);
    wcmp(2'h1, 16'h1234);
    check(compare_o[31:16], 16'h1234);
    wcmp(2'h0, 16'h1111);
    check(compare_o[15:0], 16'h1111);
    acc(1'b1, 1'b0, 1'b0, 2'h0, 8'h80);
    wcmp(2'h1, 16'h5678);
    wcmp(2'h0, 16'h9abc);
    wcmp(2'h2, 16'hdef0);
    rd(1'b1, 1'b0, 2'h1, 8'h78);
    rd(1'b1, 1'b1, 2'h0, 8'h9a);
    check(compare_o[31:16], 16'h1234);
    acc(1'b1, 1'b0, 1'b0, 2'h0, 8'h00);
    rd(1'b1, 1'b0, 2'h1, 8'h34);
    @(posedge clk_sys_i);
    channel_mode_i <= {PCRS_MODE_OTHER, PCRS_MODE_PWM_16, PCRS_MODE_PWM_N};
    pulse_ovf();
    check(compare_o[31:16], 16'h1234);
    acc(1'b1, 1'b0, 1'b0, 2'h0, 8'h08);
    pulse_ovf();
    check(compare_o[31:16], 16'h5678);
    check(compare_o[15:0], 16'h1111);
    check(compare_o[47:32], 16'h0000);
    test_done();
  end
endmodule
`default_nettype wire
